// ### design/dcp_pkg.sv
// constants and types shared by both ends of the calibration pattern readout link
// Behaviour
// - controller enables mode via third mode register, A2=1
// - controller idles all banks before enabling
// - enabled mode routes reads to pattern register
// - only reads allowed until disable with A2=0
// - read-with-precharge acts as plain read
// - no power-down, self-refresh or other commands
// - device honours reset while mode enabled
// - disabled mode: reads and writes use array
// - byte-wide: pin zero carries bit, others copy/zero
// - 16-bit: both lanes bit zero carry pattern
// - controller drives column bits one,zero as zero
// - eight-beat bursts need column bit two zero
// - chop four: bit two picks lower/upper half
// - bank and other column bits are ignored
// - burst chop per command or by mode register
// - pattern reads keep normal read latency
// - controller reads only after loop lock
// - location zero returns alternating zero-one pattern
// - beat zero is LSB, beat seven MSB
// - third register selected by bank bits 011
// - location select ignored while mode disabled
// - address bits three up written zero
package dcp_pkg;
  localparam int DQ_W = 16;
  localparam int ADDR_W = 16;
  localparam int BA_W = 3;
  localparam int BEATS = 8;
  localparam int RD_LAT = 5;
  localparam int ARRAY_WORDS = 16;
  localparam logic [2:0] BA_MR3 = 3'h3;
  localparam logic [2:0] BA_MR0 = 3'h0;
  localparam int MR3_EN_BIT = 2;
  localparam int MR0_BL_LSB = 0;
  localparam logic [1:0] BL_FIXED8 = 2'h0;
  localparam logic [1:0] BL_OTF = 2'h1;
  localparam logic [1:0] BL_FIXED4 = 2'h2;
  localparam int AP_BIT = 10;
  localparam int BC_BIT = 12;
  localparam logic [1:0] LOC_PATTERN = 2'h0;
  localparam logic [7:0] PATTERN_LOC0 = 8'hAA;
  localparam logic [7:0] PATTERN_RSVD = 8'h00;
  localparam logic [1:0] MR3_RST = 2'h0;
  localparam logic [2:0] CMD_NOP = 3'h7;
  typedef enum logic [2:0] {
    DCP_MRS = 3'h0,
    DCP_REF = 3'h1,
    DCP_PRE = 3'h2,
    DCP_ACT = 3'h3,
    DCP_WR = 3'h4,
    DCP_RD = 3'h5,
    DCP_ZQ = 3'h6,
    DCP_NOP = 3'h7
  } dcp_cmd_e;
endpackage : dcp_pkg

// ### design/dcp_if.sv
// command, address and data link between controller and device
interface dcp_if;
  import dcp_pkg::*;
  logic cmd_valid;
  dcp_cmd_e cmd;
  logic [BA_W-1:0] ba;
  logic [ADDR_W-1:0] addr;
  logic [DQ_W-1:0] wdata;
  logic [DQ_W-1:0] rdata;
  logic rdata_valid;
  logic dll_locked;
  modport device (input cmd_valid, cmd, ba, addr, wdata, output rdata, rdata_valid, dll_locked);
  modport ctrl (output cmd_valid, cmd, ba, addr, wdata, input rdata, rdata_valid, dll_locked);
endinterface : dcp_if

// ### design/dcp_beat_gen.sv
// serialises one burst of pattern or array data with fixed read latency
module dcp_beat_gen
  import dcp_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // launch
  input wire logic start,
  input wire logic chop,
  input wire logic upper_half,
  input wire logic pattern_mode,
  input wire logic [7:0] pattern,
  input wire logic [DQ_W-1:0] array_word,
  // output
  output logic [DQ_W-1:0] dq,
  output logic dq_valid
);
  logic [RD_LAT-1:0] lat_q;
  logic [3:0] left_q;
  logic [2:0] beat_q;
  logic pmode_q;
  logic [7:0] pat_q;
  logic [DQ_W-1:0] word_q;
  logic [RD_LAT-1:0] chop_p_q;
  logic [RD_LAT-1:0] up_p_q;
  logic chop_l;
  logic up_l;

  // latency pipe: pattern reads use the same latency as array reads
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      lat_q <= '0;
    end else begin
      lat_q <= {lat_q[RD_LAT-2:0], start};
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pmode_q <= 1'b0;
      pat_q <= 8'h00;
      word_q <= '0;
    end else if (start) begin
      pmode_q <= pattern_mode;
      pat_q <= pattern;
      word_q <= array_word;
    end
  end

  // burst counter; chop starts at beat four for the upper nibble
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      left_q <= 4'h0;
      beat_q <= 3'h0;
    end else if (lat_q[RD_LAT-1]) begin
      left_q <= chop_l ? 4'h4 : 4'h8;
      beat_q <= (chop_l && up_l) ? 3'h4 : 3'h0;
    end else if (left_q != 4'h0) begin
      left_q <= left_q - 4'h1;
      beat_q <= beat_q + 3'h1;
    end
  end

  // chop and half must be kept for the latency too
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      chop_p_q <= '0;
      up_p_q <= '0;
    end else begin
      chop_p_q <= {chop_p_q[RD_LAT-2:0], chop};
      up_p_q <= {up_p_q[RD_LAT-2:0], upper_half};
    end
  end
  assign chop_l = chop_p_q[RD_LAT-1];
  assign up_l = up_p_q[RD_LAT-1];

  // data register; in pattern mode every dq bit copies the pattern bit on both lanes
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      dq <= '0;
      dq_valid <= 1'b0;
    end else begin
      dq_valid <= (left_q != 4'h0);
      if (left_q == 4'h0) begin
        dq <= '0;
      end else if (pmode_q) begin
        dq <= {DQ_W{pat_q[beat_q]}};
      end else begin
        dq <= word_q ^ {{(DQ_W-3){1'b0}}, beat_q};
      end
    end
  end
endmodule : dcp_beat_gen

// ### design/dcp_device.sv
// dram end: mode registers, pattern readout and a small array
module dcp_device
  import dcp_pkg::*;
(
  // clock and reset
  input wire logic CLK_SYS,
  input wire logic RESETN,
  // link
  dcp_if.device LINK,
  // status
  output logic PATTERN_MODE,
  output logic [1:0] PATTERN_LOCATION_SELECT
);
  logic [1:0] mr3_q;
  logic mr3_en_q;
  logic [1:0] bl_q;
  logic [DQ_W-1:0] mem_q [ARRAY_WORDS];
  logic is_rd;
  logic chop;
  logic [7:0] pat;
  logic [3:0] idx;

  assign LINK.dll_locked = RESETN;
  assign idx = LINK.addr[6:3];
  assign is_rd = LINK.cmd_valid && (LINK.cmd == DCP_RD);

  // mode registers; reset still clears the pattern mode
  always_ff @(posedge CLK_SYS or negedge RESETN) begin
    if (!RESETN) begin
      mr3_en_q <= 1'b0;
      mr3_q <= MR3_RST;
      bl_q <= BL_FIXED8;
    end else if (LINK.cmd_valid && LINK.cmd == DCP_MRS) begin
      if (LINK.ba == BA_MR3) begin
        mr3_en_q <= LINK.addr[MR3_EN_BIT];
        mr3_q <= LINK.addr[1:0];
      end else if (LINK.ba == BA_MR0) begin
        bl_q <= LINK.addr[MR0_BL_LSB +: 2];
      end
    end
  end

  // location select only matters while enabled
  assign pat = (mr3_q == LOC_PATTERN) ? PATTERN_LOC0 : PATTERN_RSVD;
  assign chop = (bl_q == BL_FIXED4) || (bl_q == BL_OTF && !LINK.addr[BC_BIT]);

  // writes only reach the array in normal mode
  always_ff @(posedge CLK_SYS) begin
    if (LINK.cmd_valid && LINK.cmd == DCP_WR && !mr3_en_q) begin
      mem_q[idx] <= LINK.wdata;
    end
  end

  // auto precharge bit, bank and column bits other than bit two are not looked at in pattern mode
  dcp_beat_gen u_gen (
    .clk(CLK_SYS),
    .rst_n(RESETN),
    .start(is_rd),
    .chop(chop),
    .upper_half(LINK.addr[2]),
    .pattern_mode(mr3_en_q),
    .pattern(pat),
    .array_word(mem_q[idx]),
    .dq(LINK.rdata),
    .dq_valid(LINK.rdata_valid)
  );

  assign PATTERN_MODE = mr3_en_q;
  assign PATTERN_LOCATION_SELECT = mr3_q;
endmodule : dcp_device

// ### design/dcp_ctrl.sv
// controller end: runs pattern calibration reads on request
module dcp_ctrl
  import dcp_pkg::*;
(
  // clock and reset
  input wire logic CLK_SYS,
  input wire logic RESETN,
  // link
  dcp_if.ctrl LINK,
  // user
  input wire logic START,
  input wire logic CHOP,
  input wire logic UPPER,
  output logic BUSY,
  output logic [7:0] PATTERN_SEEN,
  output logic DONE
);
  typedef enum logic [2:0] {S_IDLE, S_PRE, S_BL, S_EN, S_RD, S_WAIT, S_DIS} dcp_state_e;
  dcp_state_e st_q;
  logic [7:0] pat_q;
  logic [3:0] cnt_q;
  logic done_q;

  always_ff @(posedge CLK_SYS or negedge RESETN) begin
    if (!RESETN) begin
      st_q <= S_IDLE;
    end else begin
      unique case (st_q)
        S_IDLE: if (START && LINK.dll_locked) st_q <= S_PRE;
        S_PRE: st_q <= S_BL;
        S_BL: st_q <= S_EN;
        S_EN: st_q <= S_RD;
        S_RD: st_q <= S_WAIT;
        S_WAIT: if (cnt_q == 4'h0 && !LINK.rdata_valid && done_q) st_q <= S_DIS;
        S_DIS: st_q <= S_IDLE;
      endcase
    end
  end

  // command drive; only reads between enable and disable
  always_comb begin
    LINK.cmd_valid = 1'b1;
    LINK.cmd = DCP_NOP;
    LINK.ba = '0;
    LINK.addr = '0;
    LINK.wdata = '0;
    unique case (st_q)
      S_PRE: begin
        LINK.cmd = DCP_PRE;
        LINK.addr[AP_BIT] = 1'b1;
      end
      // on-the-fly burst length, otherwise CHOP never reaches the device
      S_BL: begin
        LINK.cmd = DCP_MRS;
        LINK.ba = BA_MR0;
        LINK.addr[MR0_BL_LSB +: 2] = BL_OTF;
      end
      S_EN: begin
        LINK.cmd = DCP_MRS;
        LINK.ba = BA_MR3;
        LINK.addr[MR3_EN_BIT] = 1'b1;
        LINK.addr[1:0] = LOC_PATTERN;
      end
      S_RD: begin
        LINK.cmd = DCP_RD;
        LINK.addr[2] = CHOP & UPPER;
        LINK.addr[BC_BIT] = !CHOP;
      end
      S_DIS: begin
        LINK.cmd = DCP_MRS;
        LINK.ba = BA_MR3;
      end
      default: LINK.cmd_valid = 1'b0;
    endcase
  end

  // collect the returned pattern; beat index from arrival order
  always_ff @(posedge CLK_SYS or negedge RESETN) begin
    if (!RESETN) begin
      pat_q <= 8'h00;
      cnt_q <= 4'h0;
      done_q <= 1'b0;
    end else if (st_q == S_RD) begin
      cnt_q <= 4'h0;
      done_q <= 1'b0;
      pat_q <= 8'h00;
    end else if (LINK.rdata_valid) begin
      pat_q[cnt_q[2:0] + ((CHOP && UPPER) ? 3'h4 : 3'h0)] <= LINK.rdata[0];
      cnt_q <= cnt_q + 4'h1;
      done_q <= 1'b1;
    end else if (done_q) begin
      cnt_q <= 4'h0;
    end
  end

  always_ff @(posedge CLK_SYS or negedge RESETN) begin
    if (!RESETN) begin
      PATTERN_SEEN <= 8'h00;
      DONE <= 1'b0;
    end else begin
      DONE <= (st_q == S_DIS);
      if (st_q == S_DIS) PATTERN_SEEN <= pat_q;
    end
  end

  assign BUSY = (st_q != S_IDLE);
endmodule : dcp_ctrl

// ### tb/dcp_monitor.sv
// link assertions for the pattern readout pair
module dcp_monitor
  import dcp_pkg::*;
(
  // clock and reset
  input logic CLK_SYS,
  input logic RESETN,
  // link
  input logic cmd_valid,
  input dcp_cmd_e cmd,
  input logic [BA_W-1:0] ba,
  input logic [ADDR_W-1:0] addr,
  input logic [DQ_W-1:0] rdata,
  input logic rdata_valid,
  input logic dll_locked
);
  timeunit 1ns;
  timeprecision 1ps;
  logic mode_q, idle_q;
  logic [3:0] cnt_q;
  wire mrs3 = cmd_valid && cmd == DCP_MRS && ba == BA_MR3;
  wire rd = cmd_valid && cmd == DCP_RD;
  // mode is tracked from the wire, so a device slip cannot hide itself
  always_ff @(posedge CLK_SYS or negedge RESETN) begin
    if (!RESETN) begin
      mode_q <= 1'b0;
      idle_q <= 1'b0;
      cnt_q <= 4'h0;
    end else begin
      if (mrs3) mode_q <= addr[MR3_EN_BIT];
      if (cmd_valid && cmd inside {DCP_PRE, DCP_ACT}) idle_q <= cmd == DCP_PRE;
      cnt_q <= rdata_valid ? cnt_q + 4'h1 : 4'h0;
    end
  end
  default clocking cb @(posedge CLK_SYS);
  endclocking
  default disable iff (!RESETN);
  AST_MR3_ZERO: assert property (mrs3 |-> addr[15:3] == 13'h0) else $error("mode bits");
  AST_EN_IDLE: assert property (mrs3 && addr[2] |-> idle_q) else $error("not idle");
  AST_ONLY_RD: assert property (mode_q && cmd_valid |-> cmd inside {DCP_RD, DCP_MRS})
    else $error("bad cmd");
  AST_RD_LAT: assert property (rd |-> !rdata_valid [*7] ##1 rdata_valid) else $error("latency");
  AST_BEATS: assert property ($fell(rdata_valid) |-> cnt_q == 4'h4 || cnt_q == 4'h8) else $error("beats");
  AST_HOLD: assert property ($rose(rdata_valid) |-> rdata_valid [*4]) else $error("short");
  AST_DATA: assert property (mode_q && rdata_valid |-> rdata == {DQ_W{cnt_q[0]}})
    else $error("data");
  AST_COL: assert property (rd && mode_q |-> addr[1:0] == 2'h0) else $error("column");
  AST_DLL: assert property (rd |-> dll_locked) else $error("no lock");
  COV_UPPER: cover property (rd && addr[2]);
  COV_BL8: cover property ($fell(rdata_valid) && cnt_q == 4'h8);
  COV_EN: cover property (mrs3 && addr[2]);
endmodule : dcp_monitor

// ### tb/dcp_tb_top.sv
// bench: controller against device, plus a device driven by the bench
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin err_total++; $display("unexpected %0t %0h %0h", $time, a, b); end end
module dcp_tb_top
  import dcp_pkg::*;
();
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic start = 1'b0;
  logic chop = 1'b0;
  logic upper = 1'b0;
  logic busy, done, pm, pm2, hit;
  logic [7:0] seen;
  logic [31:0] rs = 32'h334E;
  logic [15:0] a;
  logic [15:0] w;
  logic [1:0] loc2;
  int err_total = 0;
  int checks_done = 0;
  dcp_if lk ();
  dcp_if lk2 ();
  dcp_ctrl i_dcp_ctrl (.CLK_SYS(clk), .RESETN(rst_n), .LINK(lk.ctrl), .START(start), .CHOP(chop), .UPPER(upper),
    .BUSY(busy), .PATTERN_SEEN(seen), .DONE(done));
  dcp_device i_dcp_device (.CLK_SYS(clk), .RESETN(rst_n), .LINK(lk.device), .PATTERN_MODE(pm),
    .PATTERN_LOCATION_SELECT());
  dcp_device i_dcp_device_2 (.CLK_SYS(clk), .RESETN(rst_n), .LINK(lk2.device), .PATTERN_MODE(pm2),
    .PATTERN_LOCATION_SELECT(loc2));
  dcp_monitor i_dcp_monitor (.CLK_SYS(clk), .RESETN(rst_n), .cmd_valid(lk.cmd_valid), .cmd(lk.cmd), .ba(lk.ba),
    .addr(lk.addr), .rdata(lk.rdata), .rdata_valid(lk.rdata_valid), .dll_locked(lk.dll_locked));
  always #12.5 clk = ~clk;
  function automatic logic [31:0] nxt();
    rs = rs ^ (rs << 13);
    rs = rs ^ (rs >> 17);
    rs = rs ^ (rs << 5);
    return rs;
  endfunction : nxt
  // beats outside the chopped nibble are never read, so they are masked out
  function automatic logic [7:0] msk(input logic c, input logic u);
    return c ? (u ? 8'hF0 : 8'h0F) : 8'hFF;
  endfunction : msk
  // beat k: pattern bit k in pattern mode, stored word xor beat index otherwise
  function automatic logic [DQ_W-1:0] beat_exp(input logic arr, input logic [DQ_W-1:0] wd, input int k);
    return arr ? (wd ^ DQ_W'(k)) : {DQ_W{PATTERN_LOC0[k]}};
  endfunction : beat_exp
  task automatic conclude();
    if (err_total == 0 && checks_done > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : conclude
  task automatic run(input logic c, input logic u);
    int n;
    chop = c;
    upper = u;
    start = 1'b1;
    hit = 1'b0;
    @(negedge clk);
    start = 1'b0;
    `CHK(busy, 1'b1)
    n = 0;
    while (done !== 1'b1 && n < 60) begin
      @(negedge clk);
      n++;
      hit |= pm;
    end
    `CHK(done, 1'b1)
    `CHK(seen & msk(c, u), 8'hAA & msk(c, u))
    `CHK(hit, 1'b1)
    `CHK(pm, 1'b0)
    `CHK(busy, 1'b0)
    @(negedge clk);
    `CHK(done, 1'b0)
  endtask : run
  task automatic c2(input dcp_cmd_e c, input logic [2:0] b, input logic [15:0] ad);
    lk2.cmd = c;
    lk2.ba = b;
    lk2.addr = ad;
    lk2.cmd_valid = 1'b1;
    @(negedge clk);
    lk2.cmd_valid = 1'b0;
    @(negedge clk);
  endtask : c2
  task automatic r2(input logic [15:0] ad, input logic [2:0] b, input int n, input int st, input logic arr,
    input logic [15:0] wd);
    int k;
    c2(DCP_RD, b, ad);
    k = 0;
    while (lk2.rdata_valid !== 1'b1 && k < 20) begin
      @(negedge clk);
      k++;
    end
    `CHK(k, 5)
    for (int i = 0; i < n; i++) begin
      `CHK(lk2.rdata, beat_exp(arr, wd, st + i))
      @(negedge clk);
    end
    `CHK(lk2.rdata_valid, 1'b0)
  endtask : r2
  // whole run is near 10 us; ten times that means a hang
  initial begin
    #100us;
    err_total++;
    conclude();
  end
  initial begin
    lk2.cmd_valid = 1'b0;
    lk2.cmd = DCP_NOP;
    lk2.ba = 3'h0;
    lk2.addr = 16'h0;
    lk2.wdata = 16'h0;
    repeat (4) @(negedge clk);
    rst_n = 1'b1;
    run(1'b0, 1'b0);
    run(1'b1, 1'b0);
    run(1'b1, 1'b1);
    repeat (6) begin
      void'(nxt());
      run(rs[0], rs[1]);
    end
    start = 1'b1;
    @(negedge clk);
    start = 1'b0;
    repeat (3) @(negedge clk);
    `CHK(pm, 1'b1)
    rst_n = 1'b0;
    #1;
    `CHK(pm, 1'b0)
    `CHK(busy, 1'b0)
    @(negedge clk);
    rst_n = 1'b1;
    run(1'b0, 1'b0);
    c2(DCP_PRE, 3'h0, 16'h0400);
    c2(DCP_MRS, BA_MR0, {14'h0, BL_FIXED4});
    c2(DCP_MRS, BA_MR3, 16'h0004);
    `CHK(pm2, 1'b1)
    r2(16'h0004, 3'h5, 4, 4, 1'b0, 16'h0000);
    c2(DCP_MRS, BA_MR3, 16'h0000);
    `CHK(pm2, 1'b0)
    void'(nxt());
    w = rs[31:16];
    lk2.wdata = w;
    c2(DCP_WR, 3'h0, 16'h0028);
    r2(16'h0028, 3'h0, 4, 0, 1'b1, w);
    c2(DCP_MRS, BA_MR0, {14'h0, BL_OTF});
    c2(DCP_MRS, BA_MR3, 16'h0004);
    repeat (8) begin
      void'(nxt());
      a = rs[15:0];
      a[2] = a[2] & ~a[12];
      a[1:0] = 2'h0;
      r2(a, rs[18:16], a[12] ? 8 : 4, a[2] ? 4 : 0, 1'b0, 16'h0000);
    end
    `CHK(pm2, 1'b1)
    c2(DCP_MRS, BA_MR3, 16'h0003);
    `CHK(pm2, 1'b0)
    `CHK(loc2, 2'h3)
    r2(16'h0028, 3'h0, 4, 0, 1'b1, w);
    conclude();
  end
endmodule : dcp_tb_top
